//--- sram_port_pkg.sv
/*
 * Shared constants of the burst-of-two separate-port memory core.
 * Assumes: one synchronous clock domain; every pin is synchronised before use.
 */
package sram_port_pkg;
    localparam int DEF_DATA_W = 36;
    localparam int DEF_LOC_W = 19;
    localparam int LANE_W = 9;
    localparam int BURST_LEN = 2;
    localparam int SYNC_STAGES = 2;
    localparam logic [0:0] BEAT_FIRST = 1'h0;
    localparam logic [0:0] BEAT_SECOND = 1'h1;
    localparam logic STROBE_RST = 1'h0;
    localparam logic STROBE_INV_RST = 1'h1;
endpackage

//--- pin_sync.sv
/*
 * Two-flop synchroniser for a group of pins.
 * Assumes: inputs are asynchronous to clk; only the second stage is read outside.
 */
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] held;
    } sync_t;

    sync_t sy_q, sy_d;

    if (WIDTH < 1) begin : g_bad_width
        $error("pin_sync: WIDTH must be at least one");
    end

    always_comb begin
        sy_d.meta = din;
        sy_d.held = sy_q.meta;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sy_q <= '0;
        end else begin
            sy_q <= sy_d;
        end
    end

    // Only the second stage leaves; the first may still be settling
    assign dout = sy_q.held;
endmodule

//--- sram_port.sv
/*
 * Double-data-rate separate-port static memory core, fixed burst of two.
 * Assumes: all pins, input clocks included, are sampled by clk (much faster than
 * the link clocks) and arrive aligned through one common synchroniser.
 */
// Functional notes
// - 1M x 36 or 2M x 18 build variants
// - every access moves exactly two words
// - read and write ports run concurrently
// - input clock rise starts each operation
// - input rise captures read side, first word
// - inverted rise captures write address, second word
// - each byte stored only when enabled
// - write data held in internal buffer
// - first read word at second inverted out rise
// - second read word at third out rise
// - output clocks both high select input clocks
// - echo strobes coincide with read data
// - write select active low
// - lane masks active low
// - low bypass input disables the loop
`timescale 1ns/1ps
module sram_port
    import sram_port_pkg::*;
#(
    parameter int DATA_W = sram_port_pkg::DEF_DATA_W,
    parameter int LOC_W = sram_port_pkg::DEF_LOC_W
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic in_clk,
    input wire logic in_clk_n,
    input wire logic out_clk,
    input wire logic out_clk_n,
    input wire logic read_sel_n,
    input wire logic write_sel_n,
    input wire logic loop_bypass_n,
    input wire logic [LOC_W-1:0] location_inputs,
    input wire logic [DATA_W/sram_port_pkg::LANE_W-1:0] lane_mask_n,
    input wire logic [DATA_W-1:0] wr_data,
    output logic [DATA_W-1:0] rd_data,
    output logic echo_strobe,
    output logic echo_strobe_inv,
    output logic dll_enabled
);
    import sram_port_pkg::*;

    localparam int MW = DATA_W / LANE_W;
    localparam int PW = 7 + LOC_W + MW + DATA_W;

    // Refused at elaboration: the array and lane split exist for two variants only
    if (!((DATA_W == 36 && LOC_W == 19) || (DATA_W == 18 && LOC_W == 20))) begin : g_bad_width
        $error("sram_port: only 36/19 and 18/20 data/location widths exist");
    end

    // Pins, clocks among them, through one synchroniser so they stay aligned
    logic [PW-1:0] pins_s;
    pin_sync #(.WIDTH(PW)) u_sync (
        .clk(clk),
        .resetn(resetn),
        .din({in_clk, in_clk_n, out_clk, out_clk_n, read_sel_n, write_sel_n,
              loop_bypass_n, location_inputs, lane_mask_n, wr_data}),
        .dout(pins_s)
    );

    logic k_s, kn_s, c_s, cn_s, rd_n_s, wr_n_s, bypass_n_s;
    logic [LOC_W-1:0] loc_s;
    logic [MW-1:0] mask_s;
    logic [DATA_W-1:0] data_s;
    assign {k_s, kn_s, c_s, cn_s, rd_n_s, wr_n_s, bypass_n_s, loc_s, mask_s, data_s} = pins_s;

    typedef struct packed {
        logic k_prev;
        logic kn_prev;
        logic c_prev;
        logic cn_prev;
        logic wr_arm;
        logic [DATA_W-1:0] arm_d0;
        logic [MW-1:0] arm_m0;
        logic wb_v;
        logic [LOC_W-1:0] wb_loc;
        logic [DATA_W-1:0] wb_d0;
        logic [DATA_W-1:0] wb_d1;
        logic [MW-1:0] wb_m0;
        logic [MW-1:0] wb_m1;
        logic s1_v;
        logic [DATA_W-1:0] s1_w0;
        logic [DATA_W-1:0] s1_w1;
        logic s2_v;
        logic [DATA_W-1:0] s2_w0;
        logic [DATA_W-1:0] s2_w1;
        logic cur_v;
        logic [DATA_W-1:0] cur_w1;
        logic [DATA_W-1:0] q;
        logic echo;
        logic echo_n;
        logic dll_on;
    } state_t;

    state_t st_q, st_d;

    logic [DATA_W-1:0] mem [0:(2**(LOC_W+1))-1];
    logic k_rise, kn_rise, op_rise, on_rise, use_k, op_lvl, on_lvl, commit;
    logic [DATA_W-1:0] fetch0, fetch1;

    // Merge new bytes over old ones where the low-active mask enables them
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_w,
                                                 input logic [DATA_W-1:0] new_w,
                                                 input logic [MW-1:0] m_n);
        logic [DATA_W-1:0] r;
        r = old_w;
        for (int i = 0; i < MW; i++) begin
            if (!m_n[i]) begin
                r[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
            end
        end
        return r;
    endfunction

    always_comb begin
        k_rise = k_s && !st_q.k_prev;
        kn_rise = kn_s && !st_q.kn_prev;
        use_k = c_s && cn_s;
        op_lvl = use_k ? k_s : c_s;
        on_lvl = use_k ? kn_s : cn_s;
        op_rise = use_k ? k_rise : (c_s && !st_q.c_prev);
        on_rise = use_k ? kn_rise : (cn_s && !st_q.cn_prev);
        commit = k_rise && st_q.wb_v;
        // Forward pending bytes so a read right behind a write is coherent
        fetch0 = mem[{loc_s, BEAT_FIRST}];
        fetch1 = mem[{loc_s, BEAT_SECOND}];
        if (st_q.wb_v && st_q.wb_loc == loc_s) begin
            fetch0 = merge(fetch0, st_q.wb_d0, st_q.wb_m0);
            fetch1 = merge(fetch1, st_q.wb_d1, st_q.wb_m1);
        end
    end

    always_comb begin
        st_d = st_q;
        st_d.k_prev = k_s;
        st_d.kn_prev = kn_s;
        st_d.c_prev = c_s;
        st_d.cn_prev = cn_s;
        st_d.dll_on = bypass_n_s;
        if (k_rise) begin
            if (commit) begin
                st_d.wb_v = 1'b0;
            end
            st_d.wr_arm = !wr_n_s;
            st_d.arm_d0 = data_s;
            st_d.arm_m0 = mask_s;
            st_d.s1_v = !rd_n_s;
            st_d.s1_w0 = fetch0;
            st_d.s1_w1 = fetch1;
            st_d.s2_v = st_q.s1_v;
            st_d.s2_w0 = st_q.s1_w0;
            st_d.s2_w1 = st_q.s1_w1;
        end
        if (kn_rise && st_q.wr_arm) begin
            // Address comes half a cycle after the first word, hence the buffer
            st_d.wr_arm = 1'b0;
            st_d.wb_v = 1'b1;
            st_d.wb_loc = loc_s;
            st_d.wb_d0 = st_q.arm_d0;
            st_d.wb_m0 = st_q.arm_m0;
            st_d.wb_d1 = data_s;
            st_d.wb_m1 = mask_s;
        end
        if (on_rise) begin
            st_d.echo_n = on_lvl;
            st_d.echo = op_lvl;
            if (st_q.s2_v) begin
                st_d.q = st_q.s2_w0;
                st_d.cur_v = 1'b1;
                st_d.cur_w1 = st_q.s2_w1;
            end
        end
        if (op_rise) begin
            st_d.echo = op_lvl;
            st_d.echo_n = on_lvl;
            if (st_q.cur_v) begin
                st_d.q = st_q.cur_w1;
                st_d.cur_v = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_q <= '0;
            st_q.echo <= STROBE_RST;
            st_q.echo_n <= STROBE_INV_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // Write port commits independently of the read fetch in the same cycle
    always_ff @(posedge clk) begin
        if (commit) begin
            mem[{st_q.wb_loc, BEAT_FIRST}] <= merge(mem[{st_q.wb_loc, BEAT_FIRST}],
                                                    st_q.wb_d0, st_q.wb_m0);
            mem[{st_q.wb_loc, BEAT_SECOND}] <= merge(mem[{st_q.wb_loc, BEAT_SECOND}],
                                                     st_q.wb_d1, st_q.wb_m1);
        end
    end

    assign rd_data = st_q.q;
    assign echo_strobe = st_q.echo;
    assign echo_strobe_inv = st_q.echo_n;
    assign dll_enabled = st_q.dll_on;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_q_on_out_edge: assert property ($changed(st_q.q) |-> $past(on_rise || op_rise))
        else $error("read data moved off an output clock edge");
    chk_second_word: assert property (op_rise && st_q.cur_v |=> !st_q.cur_v
                                      && st_q.q == $past(st_q.cur_w1))
        else $error("second burst word not driven on output rise");
    chk_first_word: assert property (on_rise && st_q.s2_v |=> st_q.cur_v
                                     && st_q.q == $past(st_q.s2_w0))
        else $error("first burst word not driven on inverted output rise");
    chk_echo_high: assert property (op_rise && !on_rise |=> echo_strobe == $past(op_lvl))
        else $error("echo strobe not aligned with output edge");
    chk_read_take: assert property (k_rise && !rd_n_s |=> st_q.s1_v ##0 !$stable(st_q.k_prev))
        else $error("read select low not taken");
    chk_write_hi: assert property (k_rise && wr_n_s |=> !st_q.wr_arm)
        else $error("high write select started a write");
    chk_buffer_fill: assert property (kn_rise && st_q.wr_arm |=> st_q.wb_v
                                      && st_q.wb_d0 == $past(st_q.arm_d0))
        else $error("write buffer not filled on inverted input rise");
    chk_pipe_step: assert property (k_rise && st_q.s1_v |=> st_q.s2_v)
        else $error("read pipeline did not advance");
    chk_dll_level: assert property (bypass_n_s [*2] |=> dll_enabled)
        else $error("loop reported off while bypass input high");
endmodule

//--- link_ctrl_model.sv
/*
 * Behavioural memory controller driving the link pins of the burst-of-two core.
 * Assumes: the bench calls cycle() back to back; each call is one 125 ns link period.
 */
`timescale 1ns/1ps
module link_ctrl_model #(
    parameter int DATA_W = 36,
    parameter int LOC_W = 19
) (
    input wire logic out_tied,
    output logic in_clk,
    output logic in_clk_n,
    output wire logic out_clk,
    output wire logic out_clk_n,
    output logic read_sel_n,
    output logic write_sel_n,
    output logic [LOC_W-1:0] location_inputs,
    output logic [DATA_W/9-1:0] lane_mask_n,
    output logic [DATA_W-1:0] wr_data
);
    localparam realtime QTR = 31.25;
    // Output pair follows the input pair unless both are tied high
    assign out_clk = out_tied | in_clk;
    assign out_clk_n = out_tied | in_clk_n;
    initial begin
        in_clk = 1'h0;
        in_clk_n = 1'h1;
        read_sel_n = 1'h1;
        write_sel_n = 1'h1;
        location_inputs = '0;
        lane_mask_n = '1;
        wr_data = '0;
    end
    task automatic cycle(input logic rd_n, input logic wr_n, input logic [LOC_W-1:0] ra, wa,
            input logic [DATA_W/9-1:0] m0, m1, input logic [DATA_W-1:0] d0, d1);
        read_sel_n = rd_n;
        write_sel_n = wr_n;
        location_inputs = ra;
        lane_mask_n = m0;
        // Unused data lines toggle so that stale values cannot pass
        wr_data = wr_n ? ~wr_data : d0;
        #QTR in_clk = 1'h1;
        in_clk_n = 1'h0;
        #QTR read_sel_n = 1'h1;
        write_sel_n = 1'h1;
        location_inputs = wa;
        lane_mask_n = m1;
        wr_data = wr_n ? ~wr_data : d1;
        #QTR in_clk = 1'h0;
        in_clk_n = 1'h1;
        #QTR;
    endtask
endmodule

//--- test_ddr_sep_port_sram_burst2.sv
/*
 * Self-checking bench of the burst-of-two separate-port memory core.
 * Assumes: link_ctrl_model drives the link; reads are judged at fixed link offsets.
 */
`timescale 1ns/1ps
module test_ddr_sep_port_sram_burst2;
    import sram_port_pkg::*;
    localparam int DW = DEF_DATA_W;
    localparam int LW = DEF_LOC_W;
    localparam int NL = DEF_DATA_W / LANE_W;
    logic clk, resetn, out_tied, loop_bypass_n, in_clk, in_clk_n, out_clk, out_clk_n;
    logic read_sel_n, write_sel_n, echo_strobe, echo_strobe_inv, dll_enabled;
    logic [LW-1:0] location_inputs;
    logic [NL-1:0] lane_mask_n;
    logic [DW-1:0] wr_data, rd_data;
    logic [DW-1:0] mem [int];
    int errors = 0;
    int compares = 0;
    sram_port DUT (.clk(clk), .resetn(resetn), .in_clk(in_clk), .in_clk_n(in_clk_n),
        .out_clk(out_clk), .out_clk_n(out_clk_n), .read_sel_n(read_sel_n),
        .write_sel_n(write_sel_n), .loop_bypass_n(loop_bypass_n),
        .location_inputs(location_inputs), .lane_mask_n(lane_mask_n), .wr_data(wr_data),
        .rd_data(rd_data), .echo_strobe(echo_strobe), .echo_strobe_inv(echo_strobe_inv),
        .dll_enabled(dll_enabled));
    link_ctrl_model #(.DATA_W(DW), .LOC_W(LW)) ctl (.out_tied(out_tied), .in_clk(in_clk),
        .in_clk_n(in_clk_n), .out_clk(out_clk), .out_clk_n(out_clk_n),
        .read_sel_n(read_sel_n), .write_sel_n(write_sel_n),
        .location_inputs(location_inputs), .lane_mask_n(lane_mask_n), .wr_data(wr_data));
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    task automatic check(input string what, input logic [DW-1:0] exp, got);
        compares++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            errors++;
        end
    endtask
    task give_verdict;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    function automatic logic [DW-1:0] merge(input logic [DW-1:0] o, n, input logic [NL-1:0] m);
        for (int i = 0; i < NL; i++) begin
            if (!m[i]) begin
                o[LANE_W*i +: LANE_W] = n[LANE_W*i +: LANE_W];
            end
        end
        return o;
    endfunction
    task automatic watch(input logic [DW-1:0] e0, e1);
        #280;
        check("word0", e0, rd_data);
        check("echo_inv", 1, DW'(echo_strobe_inv));
        #55;
        check("word1", e1, rd_data);
        check("echo", 1, DW'(echo_strobe));
    endtask
    task automatic op(input logic rd_n, wr_n, input logic [LW-1:0] ra, wa,
            input logic [NL-1:0] m0, m1, input logic [DW-1:0] d0, d1);
        logic [DW-1:0] e0, e1;
        e0 = mem[int'({ra, 1'h0})];
        e1 = mem[int'({ra, 1'h1})];
        if (!wr_n) begin
            mem[int'({wa, 1'h0})] = merge(mem[int'({wa, 1'h0})], d0, m0);
            mem[int'({wa, 1'h1})] = merge(mem[int'({wa, 1'h1})], d1, m1);
        end
        fork
            if (!rd_n) watch(e0, e1);
        join_none
        ctl.cycle(rd_n, wr_n, ra, wa, m0, m1, d0, d1);
    endtask
    task automatic idle2;
        op(1, 1, 0, 0, '1, '1, 0, 0);
        op(1, 1, 0, 0, '1, '1, 0, 0);
    endtask
    task automatic t_burst;
        op(1, 0, 0, 5, 0, 0, 36'h123456789, 36'hfedcba987);
        op(0, 0, 5, 7, 0, 0, 36'h0f0f0f0f0, 36'hc3c3c3c3c);
        op(0, 1, 7, 0, '1, '1, 0, 0);
        idle2();
        $display("burst test done");
    endtask
    task automatic t_mask;
        op(1, 0, 0, 5, 4'ha, 4'h5, 36'h5a5a5a5a5, 36'ha5a5a5a5a);
        op(1, 1, 0, 5, 0, 0, 36'h111111111, 36'h222222222);
        op(1, 1, 0, 0, '1, '1, 0, 0);
        op(0, 1, 5, 0, '1, '1, 0, 0);
        idle2();
        $display("mask test done");
    endtask
    task automatic t_tied;
        @(posedge clk) #1 out_tied = 1'h1;
        op(0, 1, 7, 0, '1, '1, 0, 0);
        idle2();
        @(posedge clk) #1 out_tied = 1'h0;
        $display("tied test done");
    endtask
    task automatic t_bypass;
        @(posedge clk) #1 loop_bypass_n = 1'h0;
        repeat (5) @(posedge clk);
        check("dll_off", 0, DW'(dll_enabled));
        #1 loop_bypass_n = 1'h1;
        repeat (5) @(posedge clk);
        check("dll_on", 1, DW'(dll_enabled));
        $display("bypass test done");
    endtask
    initial begin
        #100000;
        errors++;
        give_verdict();
    end
    initial begin
        resetn = 1'h0;
        out_tied = 1'h0;
        loop_bypass_n = 1'h1;
        repeat (6) @(posedge clk);
        check("rst_rd", 0, rd_data);
        check("rst_echo", 0, DW'(echo_strobe));
        check("rst_echo_inv", 1, DW'(echo_strobe_inv));
        check("rst_dll", 0, DW'(dll_enabled));
        #1 resetn = 1'h1;
        $display("reset test done");
        repeat (4) @(posedge clk);
        #1;
        t_burst();
        t_mask();
        t_tied();
        t_bypass();
        give_verdict();
    end
endmodule
